// >>> ext_dma_request_acceptance.sv
// one channel of an external-bus dma: request pin acceptance, a small
// transfer sequencer and an axi4-lite register slave.
// assumes ref_clk at 250 mhz and an external request pin from any domain.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`include "ext_dma_regs.svh"

module ext_dma_request_acceptance (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        ext_transfer_request_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             bus_hold,
    output logic             read_cycle,
    output logic             write_cycle,
    output logic             single_cycle,
    output logic             transfer_end_strobe_n
);
    import ext_dma_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic        sync1_reg, sync2_reg;   // request pin synchroniser
    logic        en_reg;                 // transfer_enable_bit
    logic        req_dly_reg;            // next_request_delay_bit
    logic        edge_reg;               // 1: falling edge sensing
    logic        sng_reg;                // 1: single address mode
    logic        blk_reg;                // 1: block transfer mode
    logic [15:0] count_reg;              // units left to move
    logic [7:0]  blksz_reg;              // units per block
    logic [7:0]  blk_left_reg;           // units left in this block
    logic        latched_reg;            // held request
    logic        accept_reg;             // acceptance open
    logic        high_seen_reg;          // high seen since start
    logic        wait_high_reg;          // reopen waits for high
    logic        dly_reg;                // one-clock reopen delay
    logic [1:0]  cyc_reg;                // clocks within bus cycle
    xfer_state_t state_reg, state_next;
    logic        aw_have_reg, w_have_reg;
    logic [3:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire, ctrl_wr, sw_en_set;
    logic        cyc_end, unit_end, blk_last, cnt_last, reopen, hi_ok;

    // ------------------------------------------------------------
    // request pin synchroniser
    // ------------------------------------------------------------
    // two flops before any logic looks at the pin
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= ext_transfer_request_n;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    // address and data are taken in either order; answer follows both
    assign wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign ctrl_wr   = wr_fire && aw_addr_reg == `CTRL_OFS && w_strb_reg[0];
    assign sw_en_set = ctrl_wr && w_data_reg[`CTRL_EN_BIT] && !en_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == `STAT_OFS || aw_addr_reg[1:0] != 2'h0)
                                ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                // transaction done, reopen both channels
                s_axi_bvalid  <= 1'b0;
                aw_have_reg   <= 1'b0;
                w_have_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            unique case (s_axi_araddr)
                `CTRL_OFS:  s_axi_rdata <= {27'h0, blk_reg, sng_reg, edge_reg, req_dly_reg, en_reg};
                `STAT_OFS:  s_axi_rdata <= {28'h0, wait_high_reg, state_reg != S_IDLE,
                                            accept_reg, latched_reg};
                `COUNT_OFS: s_axi_rdata <= {16'h0, count_reg};
                `BLKSZ_OFS: s_axi_rdata <= {24'h0, blksz_reg};
                default: begin
                    // unmapped offset reads zero with an error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // control, count and block size registers
    // ------------------------------------------------------------
    // a software write of the enable wins over the hardware clear at end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {blk_reg, sng_reg, edge_reg, req_dly_reg, en_reg} <= `CTRL_RST;
            count_reg <= `COUNT_RST;
            blksz_reg <= `BLKSZ_RST;
        end else begin
            if (unit_end && cnt_last)
                en_reg <= 1'b0;
            else if (unit_end)
                count_reg <= count_reg - 16'h0001;
            if (unit_end && cnt_last)
                count_reg <= 16'h0000;
            if (ctrl_wr) begin
                en_reg <= w_data_reg[`CTRL_EN_BIT];
                if (!en_reg) begin
                    // mode bits stay frozen while enabled
                    req_dly_reg <= w_data_reg[`CTRL_REQ_DLY_BIT];
                    edge_reg <= w_data_reg[`CTRL_EDGE_BIT];
                    sng_reg  <= w_data_reg[`CTRL_SNG_BIT];
                    blk_reg  <= w_data_reg[`CTRL_BLK_BIT];
                end
            end
            if (wr_fire && !en_reg && aw_addr_reg == `COUNT_OFS) begin
                if (w_strb_reg[0]) count_reg[7:0]  <= w_data_reg[7:0];
                if (w_strb_reg[1]) count_reg[15:8] <= w_data_reg[15:8];
            end
            if (wr_fire && !en_reg && aw_addr_reg == `BLKSZ_OFS && w_strb_reg[0])
                blksz_reg <= w_data_reg[7:0];
        end
    end

    // ------------------------------------------------------------
    // request acceptance
    // ------------------------------------------------------------
    assign cyc_end  = cyc_reg == `CYC_LEN - 2'h1;
    assign unit_end = (state_reg == S_WR || state_reg == S_SNG) && cyc_end;
    assign blk_last = blk_left_reg <= 8'h01;
    assign cnt_last = count_reg == 16'h0001;
    assign reopen   = unit_end && (blk_last || cnt_last) && !cnt_last;
    assign hi_ok    = !edge_reg || high_seen_reg || sync2_reg;

    // latch on a sampled low, rearm after each block or unit
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            latched_reg   <= 1'b0;
            accept_reg    <= 1'b0;
            high_seen_reg <= 1'b0;
            wait_high_reg <= 1'b0;
            dly_reg       <= 1'b0;
        end else if (!en_reg) begin
            // disabled: nothing sampled, pending request dropped
            latched_reg   <= 1'b0;
            accept_reg    <= sw_en_set;
            high_seen_reg <= 1'b0;
            wait_high_reg <= 1'b0;
            dly_reg       <= 1'b0;
        end else begin
            if (accept_reg && !sync2_reg) begin
                latched_reg <= 1'b1;
                accept_reg  <= 1'b0;
            end
            if (state_reg == S_IDLE && latched_reg && count_reg != 16'h0000) begin
                latched_reg   <= 1'b0;
                high_seen_reg <= 1'b0;
            end else if (sync2_reg) begin
                high_seen_reg <= 1'b1;
            end
            if (reopen) begin
                if (req_dly_reg)
                    dly_reg <= 1'b1;
                else if (hi_ok)
                    accept_reg <= 1'b1;
                else
                    wait_high_reg <= 1'b1;
            end
            if (dly_reg) begin
                dly_reg <= 1'b0;
                if (hi_ok)
                    accept_reg <= 1'b1;
                else
                    wait_high_reg <= 1'b1;
            end
            if (wait_high_reg && sync2_reg) begin
                wait_high_reg <= 1'b0;
                accept_reg    <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // next state of the bus-cycle sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:  if (en_reg && latched_reg && count_reg != 16'h0000)
                         state_next = S_START;
            S_START: state_next = sng_reg ? S_SNG : S_RD;
            S_RD:    if (cyc_end) state_next = S_WR;
            S_WR, S_SNG: if (cyc_end)
                         // release after one unit, or after a whole block
                         state_next = (blk_last || cnt_last) ? S_REL
                                    : (sng_reg ? S_SNG : S_RD);
            S_REL:   state_next = S_IDLE;
        endcase
    end

    // state, cycle counter and units left in the block
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= S_IDLE;
            cyc_reg      <= 2'h0;
            blk_left_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cyc_reg   <= (state_next != state_reg || cyc_end) ? 2'h0 : cyc_reg + 2'h1;
            if (state_reg == S_START)
                blk_left_reg <= blk_reg ? blksz_reg : 8'h01;
            else if (unit_end)
                blk_left_reg <= blk_left_reg - 8'h01;
        end
    end

    // bus strobes, all registered
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_hold              <= 1'b0;
            read_cycle            <= 1'b0;
            write_cycle           <= 1'b0;
            single_cycle          <= 1'b0;
            transfer_end_strobe_n <= 1'b1;
        end else begin
            bus_hold     <= state_next inside {S_RD, S_WR, S_SNG};
            read_cycle   <= state_next == S_RD;
            write_cycle  <= state_next == S_WR;
            single_cycle <= state_next == S_SNG;
            transfer_end_strobe_n <= !(unit_end && cnt_last);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    enable_opens_a: assert property ($rose(en_reg) |-> accept_reg && !latched_reg)
        else $error("acceptance not open after enable");
    low_latch_a: assert property (en_reg && accept_reg && !sync2_reg |=> latched_reg)
        else $error("sampled low not latched");
    start_clear_a: assert property (state_reg == S_IDLE && state_next == S_START
                                    |=> !latched_reg && state_reg == S_START)
        else $error("latch not cleared at start");
    edge_hold_a: assert property (en_reg && wait_high_reg && !sync2_reg |=> !accept_reg)
        else $error("acceptance reopened without high");
    level_reopen_a: assert property (en_reg && reopen && !edge_reg && !req_dly_reg
                                     |=> accept_reg)
        else $error("level mode did not reopen");
    delay_reopen_a: assert property (en_reg && reopen && req_dly_reg
                                     |=> !accept_reg ##1 (accept_reg || wait_high_reg || !en_reg))
        else $error("delayed reopen not one clock late");
    single_release_a: assert property (sng_reg && state_reg == S_SNG && cyc_end && blk_left_reg == 8'h01
                                       |=> !bus_hold ##1 state_reg == S_IDLE)
        else $error("single unit did not release bus");
    released_a: assert property (state_reg == S_REL |-> !bus_hold)
        else $error("bus held while released");
    disable_drop_a: assert property (!en_reg |=> !latched_reg)
        else $error("request kept while disabled");
    final_end_a: assert property (unit_end && cnt_last |=> !en_reg && !transfer_end_strobe_n)
        else $error("transfer end not signalled");

endmodule // ext_dma_request_acceptance

// >>> ext_dma_regs.svh
// register map, field positions, reset values and timing counts for one
// external-request dma channel; assumes a 32-bit axi4-lite register bus.
//
// Contract
// - sample request pin from edge after enable write
// - latch sampled low while acceptance is open
// - clear latched request when transfer starts
// - edge mode: see high before next low
// - edge dual: reopen after write cycle once high
// - level dual: reopen right after write cycle
// - delay bit postpones reopening one clock
// - delay dual: reopen after write plus one
// - edge single: reopen after single cycle once high
// - level single: reopen after single cycle
// - single mode releases bus after each unit; in block mode only after each block
// - released bus lets other masters run
// - repeat latch, clear, rearm until transfer end
// - block mode: one block per request
`ifndef EXT_DMA_REGS_SVH
`define EXT_DMA_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CTRL_OFS       4'h0
`define STAT_OFS       4'h4
`define COUNT_OFS      4'h8
`define BLKSZ_OFS      4'hc

// ------------------------------------------------------------
// fields of the control register and reset values
// ------------------------------------------------------------
`define CTRL_EN_BIT    0
`define CTRL_REQ_DLY_BIT 1
`define CTRL_EDGE_BIT  2
`define CTRL_SNG_BIT   3
`define CTRL_BLK_BIT   4
`define CTRL_RST       5'h00
`define COUNT_RST      16'h0000
`define BLKSZ_RST      8'h01

// ------------------------------------------------------------
// timing counts and response codes
// ------------------------------------------------------------
`define CYC_LEN        2'h2
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> ext_dma_pkg.sv
// types shared by the external-request dma channel
// assumes the constants header is compiled alongside
package ext_dma_pkg;
    // channel transfer sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_RD, S_WR, S_SNG, S_REL
    } xfer_state_t;
endpackage

// >>> ext_request_source.sv
// behavioural model of the outside device that asks the channel for transfers
// assumes the request line has a pull-up, so a released line reads high
module ext_request_source (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       issue,
    input  wire logic       hold_low,
    input  wire logic [2:0] slow,
    input  wire logic       bus_hold,
    output logic            ext_transfer_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // request bookkeeping
    // ------------------------------------------------------------
    logic [3:0] pend_reg;   // requests not yet served
    logic [2:0] dly_reg;    // idle clocks before the next request
    logic       hold_d_reg; // bus ownership one clock ago

    // drop the line while work is pending, let it float high once served
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= 4'h0;
            dly_reg <= 3'h0;
            hold_d_reg <= 1'b0;
            ext_transfer_request_n <= 1'b1;
        end else begin
            hold_d_reg <= bus_hold;
            if (hold_low) begin
                // stuck low: the device never lets go
                ext_transfer_request_n <= 1'b0;
            end else if (!ext_transfer_request_n && bus_hold && !hold_d_reg) begin
                // served: release and wait a while before asking again
                ext_transfer_request_n <= 1'b1;
                pend_reg <= pend_reg - 4'h1 + {3'h0, issue};
                dly_reg <= slow;
            end else begin
                if (issue) pend_reg <= pend_reg + 4'h1;
                if (dly_reg != 3'h0) dly_reg <= dly_reg - 3'h1;
                else ext_transfer_request_n <= (pend_reg == 4'h0);
            end
        end
    end
endmodule // ext_request_source

// >>> ext_dma_request_acceptance_test.sv
// self-checking bench for the external-request dma channel
// assumes the design files and the request source model are compiled first
`include "ext_dma_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module ext_dma_request_acceptance_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, rst_b = 1'b0, req_n, issue = 1'b0, hold_low = 1'b0;
    logic [2:0] slow = 3'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_hold, rd_c, wr_c, sg_c, end_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] bq[$];                 // expected write responses
    logic [33:0] rq[$];                // expected read response and data
    logic [7:0] seed = 8'h20;          // random source state
    int errors = 0, n_checks = 0, units = 0, holds = 0, ends = 0, cyc = 0, last = 0, gap = 0, wrs = 0;
    int u0, h0, e0, g0, n;
    logic pu = 1'b0, ph = 1'b0, pw = 1'b0;
    logic [1:0] eb;                    // oldest write note, popped once
    logic [33:0] er;                   // oldest read note, popped once

    always #2 ref_clk = ~ref_clk;

    ext_dma_request_acceptance dut (.ref_clk(ref_clk), .rst_b(rst_b), .ext_transfer_request_n(req_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus_hold(bus_hold),
        .read_cycle(rd_c), .write_cycle(wr_c), .single_cycle(sg_c), .transfer_end_strobe_n(end_n));

    ext_request_source src (.ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .hold_low(hold_low),
        .slow(slow), .bus_hold(bus_hold), .ext_transfer_request_n(req_n));

    // ------------------------------------------------------------
    // result watcher: bus answers against queued notes, unit counting
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        // pop first: the compare macro reads its expectation twice
        if (s_axi_bvalid && s_axi_bready) begin
            eb = bq.pop_front();
            `CHK(s_axi_bresp, eb)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            er = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
        cyc++;
        if ((rd_c || sg_c) && !pu) begin
            units++;
            gap = cyc - last;
            last = cyc;
        end
        if (bus_hold && !ph) holds++;
        if (wr_c && !pw) wrs++;
        pw = wr_c;
        if (!end_n) ends++;
        pu = rd_c || sg_c;
        ph = bus_hold;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic fail_wait();
        errors++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        give_verdict();
    endtask

    // axi4-lite write; address and data offered together, released when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        k = 0;
        bq.push_back(r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 50);
        s_axi_bready <= 1'b0;
        if (k >= 50) fail_wait();
    endtask

    // axi4-lite read; the expectation goes to the queue before the request
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        int k;
        k = 0;
        rq.push_back(e);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 50);
        s_axi_rready <= 1'b0;
        if (k >= 50) fail_wait();
    endtask

    // bounded wait until a counter reaches a target
    task automatic wait_for(ref int v, input int t);
        int k;
        k = 0;
        while (v < t && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 400) fail_wait();
    endtask

    task automatic pulse_issue(input int c);
        @(posedge ref_clk);
        issue <= 1'b1;
        repeat (c) @(posedge ref_clk);
        issue <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values and a read-only register
        rd(`CTRL_OFS, 34'h0);
        rd(`BLKSZ_OFS, {2'h0, 24'h0, `BLKSZ_RST});
        rd(`STAT_OFS, 34'h0);
        wr(`STAT_OFS, 32'hf, `RESP_SLVERR);
        $display("test registers done");
        // level dual: a random number of requests, one unit each
        seed = lfsr(seed);
        n = 2 + seed % 3;
        slow <= seed[2:0];
        wr(`COUNT_OFS, n, `RESP_OKAY);
        {u0, e0} = {units, ends};
        wr(`CTRL_OFS, 32'h1, `RESP_OKAY);
        pulse_issue(n);
        wait_for(ends, e0 + 1);
        `CHK(units - u0, n)
        `CHK(wrs, units)
        rd(`CTRL_OFS, 34'h0);
        $display("test level dual done");
        // disabled channel ignores a low pin, then samples once enabled
        wr(`COUNT_OFS, 32'h2, `RESP_OKAY);
        hold_low <= 1'b1;
        u0 = units;
        repeat (20) @(posedge ref_clk);
        `CHK(units - u0, 0)
        wr(`CTRL_OFS, 32'h1, `RESP_OKAY);
        wait_for(units, u0 + 1);
        wr(`CTRL_OFS, 32'h0, `RESP_OKAY);
        repeat (20) @(posedge ref_clk);
        $display("test enable done");
        // steady low pin: delay bit adds exactly one clock between units
        for (int m = 0; m < 2; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(`COUNT_OFS, 32'h3, `RESP_OKAY);
                {u0, h0, e0} = {units, holds, ends};
                wr(`CTRL_OFS, 32'h1 | (d << 1) | (m << 3), `RESP_OKAY);
                wait_for(ends, e0 + 1);
                `CHK(units - u0, 3)
                `CHK(holds - h0, 3)
                if (d == 0) g0 = gap;
                else `CHK(gap - g0, 1)
            end
        end
        $display("test delay done");
        // edge sensing: a pin stuck low gives one unit only
        for (int m = 0; m < 2; m++) begin
            hold_low <= 1'b1;
            wr(`COUNT_OFS, 32'h2, `RESP_OKAY);
            {u0, e0} = {units, ends};
            wr(`CTRL_OFS, 32'h5 | (m << 3), `RESP_OKAY);
            wait_for(units, u0 + 1);
            repeat (30) @(posedge ref_clk);
            `CHK(units - u0, 1)
            hold_low <= 1'b0;
            repeat (4) @(posedge ref_clk);
            pulse_issue(1);
            wait_for(ends, e0 + 1);
            `CHK(units - u0, 2)
        end
        $display("test edge done");
        // block mode: one request moves a whole block
        wr(`BLKSZ_OFS, 32'h2, `RESP_OKAY);
        wr(`COUNT_OFS, 32'h4, `RESP_OKAY);
        {u0, h0, e0} = {units, holds, ends};
        wr(`CTRL_OFS, 32'h11, `RESP_OKAY);
        pulse_issue(1);
        wait_for(units, u0 + 2);
        repeat (30) @(posedge ref_clk);
        `CHK(units - u0, 2)
        `CHK(holds - h0, 1)
        pulse_issue(1);
        wait_for(ends, e0 + 1);
        `CHK(units - u0, 4)
        $display("test block done");
        give_verdict();
    end
endmodule // ext_dma_request_acceptance_test
